// *** rtl/sapc_params.svh ***
`ifndef SAPC_PARAMS_SVH
`define SAPC_PARAMS_SVH

// Register byte addresses on the AXI4-Lite port.
`define SAPC_A_CTRL  8'h00
`define SAPC_A_FBDIV 8'h04
`define SAPC_A_XM_LO 8'h08
`define SAPC_A_XM_HI 8'h0c
`define SAPC_A_XN    8'h10
`define SAPC_A_STAT  8'h14
`define SAPC_A_GPIO  8'h18
`define SAPC_A_LIM   8'h1c

// Feedback divider limits and built-in defaults.
`define SAPC_FB_MIN  10'h07a
`define SAPC_FB_MAX  10'h230
`define SAPC_FB_DEF  10'h114
`define SAPC_XM_DEF  48'h0000_0000_0019
`define SAPC_XN_DEF  16'h0001

// Bus responses.
`define SAPC_OKAY    2'h0
`define SAPC_SLVERR  2'h2

// Status register bit positions.
`define SAPC_ST_DONE 0
`define SAPC_ST_SRC  1
`define SAPC_ST_LOCK 3
`define SAPC_ST_LOL  4
`define SAPC_ST_ERR  5

// Timing: times in ns, counts derived from the 5 ns clock.
`define SAPC_CLK_NS  5
`define SAPC_BOOT_NS 200
`define SAPC_QUAL_NS 2000
`define SAPC_BOOT_CYC ((`SAPC_BOOT_NS + `SAPC_CLK_NS - 1) / `SAPC_CLK_NS)
`define SAPC_QUAL_CYC ((`SAPC_QUAL_NS + `SAPC_CLK_NS - 1) / `SAPC_CLK_NS)

// Loop filter control code window.
`define SAPC_V_MID   8'h80
`define SAPC_V_BASE  8'h10
`define SAPC_V_DBL   8'h08

`endif

// *** rtl/sapc_pkg.sv ***
`include "sapc_params.svh"

package sapc_pkg;

  typedef logic [9:0]  sapc_fb_t;
  typedef logic [47:0] sapc_num_t;
  typedef logic [15:0] sapc_den_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_OTP  = 2'h1,
    SRC_EE   = 2'h2
  } sapc_src_e;

  typedef enum logic [1:0] {
    BT_WAIT = 2'h0,
    BT_LOAD = 2'h1,
    BT_DONE = 2'h3
  } sapc_boot_e;

  typedef enum logic [1:0] {
    LK_UNL  = 2'h0,
    LK_QUAL = 2'h1,
    LK_LCK  = 2'h3
  } sapc_lock_e;

  // Boot source pins and loop control code after synchronisation.
  typedef struct packed {
    logic     otp_en;
    logic     otp_valid;
    logic     otp_dbl;
    sapc_fb_t otp_fb;
    logic     ee_en;
    logic     ee_valid;
    logic     ee_dbl;
    sapc_fb_t ee_fb;
    logic [7:0] vctrl;
  } sapc_pins_s;

  // True when a feedback divider value is one the loop can run at.
  function automatic logic sapc_fb_ok(input sapc_fb_t fb);
    sapc_fb_ok = (fb >= `SAPC_FB_MIN) && (fb <= `SAPC_FB_MAX);
  endfunction : sapc_fb_ok

  // Byte-lane merge of a bus write into an existing word.
  function automatic logic [31:0] sapc_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
    sapc_merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        sapc_merge[i*8 +: 8] = wd[i*8 +: 8];
  endfunction : sapc_merge

endpackage : sapc_pkg

// *** rtl/sapc_boot.sv ***
`timescale 1ns/1ps
`include "sapc_params.svh"

module sapc_boot
  import sapc_pkg::*;
#(
  parameter int BOOT_CYC = `SAPC_BOOT_CYC
)
(
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Synchronised boot pins.
  input  wire sapc_pkg::sapc_pins_s pins,
  // Loaded configuration.
  output logic                  done,
  output sapc_pkg::sapc_src_e   src,
  output logic                  dbl,
  output sapc_pkg::sapc_fb_t    fb
);
  localparam int CW = $clog2(BOOT_CYC + 1);

  if (BOOT_CYC < 1) begin : g_chk
    $error("sapc_boot: BOOT_CYC must be at least 1");
  end

  typedef struct packed {
    sapc_boot_e     state;
    logic [CW-1:0]  cnt;
    logic           done;
    sapc_src_e      src;
    logic           dbl;
    sapc_fb_t       fb;
  } sapc_boot_s;

  sapc_boot_s st_q;
  sapc_boot_s st_d;
  logic       otp_use;
  logic       ee_use;

  // A source is used only when enabled, valid and holding a legal divider.
  assign otp_use = pins.otp_en && pins.otp_valid && sapc_fb_ok(pins.otp_fb);
  assign ee_use  = pins.ee_en && pins.ee_valid && sapc_fb_ok(pins.ee_fb);

  // Wait for the straps to settle, then load once; OTP has priority.
  always_comb
  begin
    st_d      = st_q;
    st_d.done = 1'b0;
    unique case (st_q.state)
      BT_WAIT:
      begin
        if (st_q.cnt == CW'(BOOT_CYC - 1))
          st_d.state = BT_LOAD;
        else
          st_d.cnt = st_q.cnt + CW'(1);
      end
      BT_LOAD:
      begin
        st_d.state = BT_DONE;
        st_d.done  = 1'b1;
        if (otp_use)
        begin
          st_d.src = SRC_OTP; // RULE_05
          st_d.dbl = pins.otp_dbl;
          st_d.fb  = pins.otp_fb;
        end
        else if (ee_use)
        begin
          st_d.src = SRC_EE; // RULE_05
          st_d.dbl = pins.ee_dbl;
          st_d.fb  = pins.ee_fb;
        end
        // Otherwise the built-in defaults stay in place. RULE_09
      end
      BT_DONE: st_d.state = BT_DONE;
      default: st_d.state = BT_WAIT;
    endcase
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '{state: BT_WAIT, cnt: '0, done: 1'b0, src: SRC_NONE,
                dbl: 1'b0, fb: `SAPC_FB_DEF};
    end
    else
      st_q <= st_d;
  end

  assign done = st_q.done;
  assign src  = st_q.src;
  assign dbl  = st_q.dbl;
  assign fb   = st_q.fb;

  sequence s_load;
    st_q.state == BT_LOAD;
  endsequence

  property p_boot_otp;
    @(posedge aclk) disable iff (!aresetn)
    (s_load and otp_use) |=>
      (done && src == SRC_OTP && fb == $past(pins.otp_fb));
  endproperty
  a_boot_otp: assert property (p_boot_otp) // RULE_05
    else $error("OTP load did not take the OTP settings.");

  property p_boot_def;
    @(posedge aclk) disable iff (!aresetn)
    (s_load and (!otp_use && !ee_use)) |=>
      (done && src == SRC_NONE && fb == `SAPC_FB_DEF && !dbl);
  endproperty
  a_boot_def: assert property (p_boot_def) // RULE_09
    else $error("Defaults were not kept with no boot source.");

endmodule : sapc_boot

// *** rtl/sapc_lock.sv ***
`timescale 1ns/1ps
`include "sapc_params.svh"

module sapc_lock
  import sapc_pkg::*;
#(
  parameter int QUAL_CYC = `SAPC_QUAL_CYC
)
(
  // Clock and reset.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Active configuration and loop control code.
  input  wire logic [7:0]    vctrl,
  input  wire logic          dbl,
  input  wire sapc_pkg::sapc_fb_t fb,
  input  wire logic          restart,
  // Lock state and window.
  output logic               locked,
  output logic               lol,
  output logic [7:0]         lim_lo,
  output logic [7:0]         lim_hi
);
  localparam int QW = $clog2(QUAL_CYC + 1);

  if (QUAL_CYC < 1) begin : g_chk
    $error("sapc_lock: QUAL_CYC must be at least 1");
  end

  typedef struct packed {
    sapc_lock_e    state;
    logic [QW-1:0] cnt;
    logic          lol;
  } sapc_lock_s;

  sapc_lock_s st_q;
  sapc_lock_s st_d;
  logic [7:0] span;
  logic       in_rng;

  // Window half-width grows with the divider and with the doubler.
  assign span   = `SAPC_V_BASE + {3'h0, fb[9:5]} // RULE_07
                + (dbl ? `SAPC_V_DBL : 8'h00);
  assign lim_lo = `SAPC_V_MID - span;
  assign lim_hi = `SAPC_V_MID + span;
  assign in_rng = (vctrl >= lim_lo) && (vctrl <= lim_hi);

  // Qualify for a full window before declaring lock.
  always_comb
  begin
    st_d     = st_q;
    st_d.lol = 1'b0;
    if (restart)
    begin
      st_d.state = LK_UNL;
      st_d.cnt   = '0;
      st_d.lol   = (st_q.state == LK_LCK);
    end
    else
    begin
      unique case (st_q.state)
        LK_UNL:
        begin
          st_d.cnt = '0;
          if (in_rng)
            st_d.state = LK_QUAL;
        end
        LK_QUAL:
        begin
          if (!in_rng)
            st_d.state = LK_UNL;
          else if (st_q.cnt == QW'(QUAL_CYC - 1))
            st_d.state = LK_LCK; // RULE_07
          else
            st_d.cnt = st_q.cnt + QW'(1);
        end
        LK_LCK:
        begin
          if (!in_rng)
          begin
            st_d.state = LK_UNL;
            st_d.lol   = 1'b1; // RULE_08
          end
        end
        default: st_d.state = LK_UNL;
      endcase
    end
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '{state: LK_UNL, cnt: '0, lol: 1'b0};
    else
      st_q <= st_d;
  end

  assign locked = (st_q.state == LK_LCK);
  assign lol    = st_q.lol;

  property p_lose;
    @(posedge aclk) disable iff (!aresetn)
    (locked && !in_rng && !restart) |=> (lol && !locked);
  endproperty
  a_lose: assert property (p_lose) // RULE_08
    else $error("Leaving the window did not raise loss of lock.");

  property p_qual;
    @(posedge aclk) disable iff (!aresetn)
    (st_q.state == LK_QUAL && st_q.cnt == QW'(QUAL_CYC - 1) && in_rng
     && !restart) |=> locked;
  endproperty
  a_qual: assert property (p_qual) // RULE_07
    else $error("Lock not declared after full qualification.");

endmodule : sapc_lock

// *** rtl/sapc_top.sv ***
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sapc_params.svh"

// Function
// [RULE_01] Frequencies are held as a 48-bit numerator over a 16-bit denominator.
// [RULE_02] A setting chooses the crystal directly or through the doubler.
// [RULE_03] The feedback divider takes integers 122 to 560 and nothing else.
// [RULE_04] Software should pick settings for a 13.4GHz-13.9GHz loop.
// [RULE_05] At reset the settings load from OTP or EEPROM, whichever is valid.
// [RULE_06] After boot the host may rewrite the settings at any time.
// [RULE_07] Lock limits are derived from the active settings, not programmed.
// [RULE_08] Loss of lock is flagged in status and can drive a GPIO.
// [RULE_09] With no valid boot source the built-in defaults remain.
module sapc_top
  import sapc_pkg::*;
#(
  parameter int QUAL_CYC = `SAPC_QUAL_CYC,
  parameter int BOOT_CYC = `SAPC_BOOT_CYC
)
(
  // Clock and reset.
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Boot sources.
  input  wire logic                otp_en,
  input  wire logic                otp_valid,
  input  wire logic                otp_dbl,
  input  wire sapc_pkg::sapc_fb_t  otp_fb,
  input  wire logic                ee_en,
  input  wire logic                ee_valid,
  input  wire logic                ee_dbl,
  input  wire sapc_pkg::sapc_fb_t  ee_fb,
  // Loop filter control code.
  input  wire logic [7:0]          vctrl_code,
  // PLL controls and status pin.
  output logic                     system_analog_pll_doubler_en,
  output sapc_pkg::sapc_fb_t       system_analog_pll_fbdiv,
  output logic                     gpio_status
);

  typedef struct packed {
    sapc_pins_s pin_s1;
    sapc_pins_s pin_s2;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       aw_full;
    logic       w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic       dbl;
    sapc_fb_t   fb;
    sapc_num_t  xm;
    sapc_den_t  xn;
    logic       boot_done;
    sapc_src_e  boot_src;
    logic       lol_sticky;
    logic       cfg_err;
    logic       gpio_sel;
    logic       gpio_drv;
    logic       gpio;
    logic       restart;
  } sapc_state_s;

  sapc_state_s st_q;
  sapc_state_s st_d;
  sapc_pins_s  pins_in;
  logic        wr_go;
  logic        bt_done;
  sapc_src_e   bt_src;
  logic        bt_dbl;
  sapc_fb_t    bt_fb;
  logic        locked;
  logic        lol;
  logic [7:0]  lim_lo;
  logic [7:0]  lim_hi;

  // Pins are gathered so the whole group goes through two flip-flops.
  assign pins_in = '{otp_en: otp_en, otp_valid: otp_valid,
                     otp_dbl: otp_dbl, otp_fb: otp_fb, ee_en: ee_en,
                     ee_valid: ee_valid, ee_dbl: ee_dbl, ee_fb: ee_fb,
                     vctrl: vctrl_code};

  // A write executes once address and data are both held.
  assign wr_go = st_q.aw_full && st_q.w_full && !st_q.bvalid;

  sapc_boot #(
    .BOOT_CYC (BOOT_CYC)
  ) u_boot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (st_q.pin_s2),
    .done    (bt_done),
    .src     (bt_src),
    .dbl     (bt_dbl),
    .fb      (bt_fb)
  );

  sapc_lock #(
    .QUAL_CYC (QUAL_CYC)
  ) u_lock (
    .aclk    (aclk),
    .aresetn (aresetn),
    .vctrl   (st_q.pin_s2.vctrl),
    .dbl     (st_q.dbl),
    .fb      (st_q.fb),
    .restart (st_q.restart),
    .locked  (locked),
    .lol     (lol),
    .lim_lo  (lim_lo),
    .lim_hi  (lim_hi)
  );

  // Bus slave, boot load, sticky flags and status pin in one step.
  always_comb
  begin
    logic [31:0] nv;
    logic        clr_lol;
    logic        clr_err;
    logic        bad;
    nv      = 32'h0000_0000;
    clr_lol = 1'b0;
    clr_err = 1'b0;
    bad     = 1'b0;
    st_d         = st_q;
    st_d.pin_s1  = pins_in;
    st_d.pin_s2  = st_q.pin_s1;
    st_d.restart = 1'b0;

    // Boot load replaces the defaults once. CTRL and FBDIV writes before it get SLVERR.
    if (bt_done)
    begin
      st_d.dbl       = bt_dbl; // RULE_05
      st_d.fb        = bt_fb;
      st_d.boot_src  = bt_src;
      st_d.boot_done = 1'b1;
      st_d.restart   = 1'b1;
    end

    // Address and data are taken independently.
    if (awvalid && st_q.awready)
    begin
      st_d.aw_addr = {awaddr[7:2], 2'h0};
      st_d.aw_full = 1'b1;
      st_d.awready = 1'b0;
    end
    if (wvalid && st_q.wready)
    begin
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
      st_d.w_full = 1'b1;
      st_d.wready = 1'b0;
    end

    if (wr_go)
    begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      unique case (st_q.aw_addr)
        `SAPC_A_CTRL:
        begin
          nv  = sapc_merge({31'h0, st_q.dbl}, st_q.w_data, st_q.w_strb);
          bad = !st_q.boot_done; // RULE_06
          if (!bad)
          begin
            st_d.dbl     = nv[0]; // RULE_02
            st_d.restart = (nv[0] != st_q.dbl);
          end
        end
        `SAPC_A_FBDIV:
        begin
          nv  = sapc_merge({22'h0, st_q.fb}, st_q.w_data, st_q.w_strb);
          bad = !st_q.boot_done || (nv[31:10] != 22'h0)
              || !sapc_fb_ok(nv[9:0]); // RULE_03
          if (!bad)
          begin
            st_d.fb      = nv[9:0]; // RULE_06
            st_d.restart = (nv[9:0] != st_q.fb);
          end
        end
        `SAPC_A_XM_LO:
        begin
          nv = sapc_merge(st_q.xm[31:0], st_q.w_data, st_q.w_strb);
          st_d.xm[31:0] = nv; // RULE_01
        end
        `SAPC_A_XM_HI:
        begin
          nv = sapc_merge({16'h0, st_q.xm[47:32]}, st_q.w_data,
                          st_q.w_strb);
          st_d.xm[47:32] = nv[15:0]; // RULE_01
        end
        `SAPC_A_XN:
        begin
          nv  = sapc_merge({16'h0, st_q.xn}, st_q.w_data, st_q.w_strb);
          // A zero denominator would make the ratio meaningless.
          bad = (nv[15:0] == 16'h0000); // RULE_01
          if (!bad)
            st_d.xn = nv[15:0];
        end
        `SAPC_A_STAT:
        begin
          clr_lol = st_q.w_strb[0] && st_q.w_data[`SAPC_ST_LOL];
          clr_err = st_q.w_strb[0] && st_q.w_data[`SAPC_ST_ERR];
        end
        `SAPC_A_GPIO:
        begin
          nv = sapc_merge({30'h0, st_q.gpio_drv, st_q.gpio_sel},
                          st_q.w_data, st_q.w_strb);
          st_d.gpio_sel = nv[0];
          st_d.gpio_drv = nv[1];
        end
        `SAPC_A_LIM: bad = 1'b0;
        default:     bad = 1'b1;
      endcase
      st_d.bresp = bad ? `SAPC_SLVERR : `SAPC_OKAY;
    end

    // Both channels reopen only once the response has been taken.
    if (st_q.bvalid && bready)
    begin
      st_d.bvalid  = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end

    // A new event wins over a software clear in the same cycle.
    st_d.lol_sticky = (st_q.lol_sticky && !clr_lol) || lol; // RULE_08
    st_d.cfg_err    = (st_q.cfg_err && !clr_err) || (wr_go && bad);

    // Status pin follows the latched alarm or a software level.
    st_d.gpio = st_q.gpio_sel ? st_q.lol_sticky : st_q.gpio_drv; // RULE_08

    // Read: data is registered, so rvalid comes one cycle after arvalid.
    if (arvalid && st_q.arready)
    begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = `SAPC_OKAY;
      st_d.rdata   = 32'h0000_0000;
      unique case ({araddr[7:2], 2'h0})
        `SAPC_A_CTRL:  st_d.rdata = {31'h0, st_q.dbl};
        `SAPC_A_FBDIV: st_d.rdata = {22'h0, st_q.fb};
        `SAPC_A_XM_LO: st_d.rdata = st_q.xm[31:0];
        `SAPC_A_XM_HI: st_d.rdata = {16'h0, st_q.xm[47:32]};
        `SAPC_A_XN:    st_d.rdata = {16'h0, st_q.xn};
        `SAPC_A_STAT:
        begin
          st_d.rdata[`SAPC_ST_DONE]       = st_q.boot_done;
          st_d.rdata[`SAPC_ST_SRC +: 2]   = st_q.boot_src;
          st_d.rdata[`SAPC_ST_LOCK]       = locked;
          st_d.rdata[`SAPC_ST_LOL]        = st_q.lol_sticky; // RULE_08
          st_d.rdata[`SAPC_ST_ERR]        = st_q.cfg_err;
        end
        `SAPC_A_GPIO:  st_d.rdata = {30'h0, st_q.gpio_drv, st_q.gpio_sel};
        `SAPC_A_LIM:   st_d.rdata = {16'h0, lim_hi, lim_lo}; // RULE_07
        default:       st_d.rresp = `SAPC_SLVERR;
      endcase
    end
    if (st_q.rvalid && rready)
    begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
  end

  // State register; pins and the defaults come up as constants.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q            <= '0;
      st_q.awready    <= 1'b1;
      st_q.wready     <= 1'b1;
      st_q.arready    <= 1'b1;
      st_q.fb         <= `SAPC_FB_DEF; // RULE_09
      st_q.xm         <= `SAPC_XM_DEF;
      st_q.xn         <= `SAPC_XN_DEF;
      st_q.boot_src   <= SRC_NONE;
    end
    else
      st_q <= st_d;
  end

  assign awready         = st_q.awready;
  assign wready          = st_q.wready;
  assign bvalid          = st_q.bvalid;
  assign bresp           = st_q.bresp;
  assign arready         = st_q.arready;
  assign rvalid          = st_q.rvalid;
  assign rresp           = st_q.rresp;
  assign rdata           = st_q.rdata;
  assign system_analog_pll_doubler_en = st_q.dbl;
  assign system_analog_pll_fbdiv      = st_q.fb;
  assign gpio_status     = st_q.gpio;

  sequence s_wr_fb;
    wr_go && st_q.aw_addr == `SAPC_A_FBDIV && st_q.boot_done
      && st_q.w_strb[1:0] == 2'h3 && st_q.w_data[31:10] == 22'h0
      && sapc_fb_ok(st_q.w_data[9:0]);
  endsequence

  property p_fb_range;
    @(posedge aclk) disable iff (!aresetn)
    sapc_fb_ok(system_analog_pll_fbdiv);
  endproperty
  a_fb_range: assert property (p_fb_range) // RULE_03
    else $error("Feedback divider left its legal range.");

  property p_host_fb;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_fb |=> (system_analog_pll_fbdiv == $past(st_q.w_data[9:0])
                 && bvalid && bresp == `SAPC_OKAY);
  endproperty
  a_host_fb: assert property (p_host_fb) // RULE_06
    else $error("Host divider write was not applied.");

  property p_pre_boot;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && !st_q.boot_done && st_q.aw_addr == `SAPC_A_FBDIV)
      |=> (bresp == `SAPC_SLVERR && $stable(system_analog_pll_fbdiv));
  endproperty
  a_pre_boot: assert property (p_pre_boot) // RULE_06
    else $error("Divider write before boot was not refused.");

  property p_dbl;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && st_q.boot_done && st_q.aw_addr == `SAPC_A_CTRL
      && st_q.w_strb[0]) |=> (system_analog_pll_doubler_en == $past(st_q.w_data[0]));
  endproperty
  a_dbl: assert property (p_dbl) // RULE_02
    else $error("Doubler select write was not applied.");

  property p_lol_sticky;
    @(posedge aclk) disable iff (!aresetn)
    lol |=> st_q.lol_sticky ##1 (!st_q.gpio_sel || gpio_status);
  endproperty
  a_lol_sticky: assert property (p_lol_sticky) // RULE_08
    else $error("Loss of lock was not latched or not on the pin.");

  property p_ratio;
    @(posedge aclk) disable iff (!aresetn)
    st_q.xn != 16'h0000;
  endproperty
  a_ratio: assert property (p_ratio) // RULE_01
    else $error("Frequency denominator became zero.");

endmodule : sapc_top

// *** bench/sapc_mem_model.sv ***
`timescale 1ns/1ps

// Boot memories and loop filter seen from the device pins, as plain levels.
module sapc_mem_model
(
  // Scenario select and loop code.
  input  wire logic [1:0] mode,
  input  wire logic [7:0] vin,
  // Boot memory pins.
  output logic            otp_en,
  output logic            otp_valid,
  output logic            otp_dbl,
  output logic [9:0]      otp_fb,
  output logic            ee_en,
  output logic            ee_valid,
  output logic            ee_dbl,
  output logic [9:0]      ee_fb,
  // Loop filter code.
  output logic [7:0]      vctrl_code
);
  // OTP stays enabled but is only valid in mode 1, so mode 2 forces
  // the fall back onto the EEPROM image.
  assign otp_en     = 1'b1;
  assign otp_valid  = (mode == 2'h1);
  assign otp_dbl    = 1'b1;
  // Images hold legal dividers, 200 with the doubler in OTP and 150 without in EEPROM.
  assign otp_fb     = 10'h0c8;
  assign ee_en      = (mode == 2'h2);
  assign ee_valid   = 1'b1;
  assign ee_dbl     = 1'b0;
  assign ee_fb      = 10'h096;
  assign vctrl_code = vin;
endmodule : sapc_mem_model

// *** bench/test_system_system_analog_pll_config_status.sv ***
`timescale 1ns/1ps

module test_system_system_analog_pll_config_status;
  import sapc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, vin = 8'h80;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] mode = 2'h0, resp;
  wire awready, wready, bvalid, arready, rvalid, gpio_status;
  wire otp_en, otp_valid, otp_dbl, ee_en, ee_valid, ee_dbl;
  wire system_analog_pll_doubler_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [9:0] otp_fb, ee_fb, system_analog_pll_fbdiv;
  wire [7:0] vctrl_code;
  int n_mismatch = 0, total_checks = 0;

  // Short counts keep boot and lock qualification quick.
  sapc_top #(.QUAL_CYC(4), .BOOT_CYC(2)) u_dut (.*);
  sapc_mem_model u_mem (.*);

  // Clock generator.
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [47:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // A wait that ran out of its bound ends the run at once.
  task automatic wt(input int n);
    if (n >= 200)
    begin
      chk("wait", 48'h0, 48'h1);
      end_of_test();
    end
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    wt(n);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    wt(n);
  endtask : rdr

  task automatic poll(input int b);
    int n;
    for (n = 0; n < 200; n++)
    begin
      rdr(8'h14);
      if (rd[b] === 1'b1) break;
    end
    wt(n);
  endtask : poll

  task automatic boot(input logic [1:0] m, input logic [9:0] f, input logic d);
    @(posedge aclk);
    mode <= m;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    poll(0);
    chk("src", m, rd[2:1]);
    chk("fbdiv", f, system_analog_pll_fbdiv);
    chk("dbl", d, system_analog_pll_doubler_en);
  endtask : boot

  // Window edge 0x9e is left by one step to catch an off-by-one limit.
  task automatic t_lock();
    rdr(8'h1c);
    chk("lim", 48'h9e62, rd[15:0]);
    poll(3);
    wr(8'h18, 32'h1);
    chk("gpio", 48'h0, gpio_status);
    @(posedge aclk);
    vin <= 8'h9f;
    poll(4);
    chk("lock", 48'h0, rd[3]);
    chk("gpio", 48'h1, gpio_status);
    wr(8'h14, 32'h10);
    rdr(8'h14);
    chk("lol", 48'h0, rd[4]);
    chk("gpio", 48'h0, gpio_status);
    wr(8'h18, 32'h2);
    @(posedge aclk);
    chk("gpio_sw", 48'h1, gpio_status);
  endtask : t_lock

  task automatic t_cfg();
    logic [9:0] v[4] = '{10'h079, 10'h07a, 10'h230, 10'h231};
    logic [9:0] ef[4] = '{10'h0c8, 10'h07a, 10'h230, 10'h230};
    logic [1:0] er[4] = '{2'h2, 2'h0, 2'h0, 2'h2};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, {22'h0, v[i]});
      chk("fb_resp", er[i], resp);
      chk("fbdiv", ef[i], system_analog_pll_fbdiv);
    end
    rdr(8'h14);
    chk("err", 48'h1, rd[5]);
    wr(8'h00, 32'h0);
    chk("dbl", 48'h0, system_analog_pll_doubler_en);
    rdr(8'h1c);
    chk("lim", 48'ha15f, rd[15:0]);
  endtask : t_cfg

  task automatic t_freq();
    rdr(8'h08);
    chk("xm_lo", 48'h19, rd);
    wr(8'h08, 32'haaaa5555);
    wr(8'h0c, 32'h00001234);
    wr(8'h10, 32'h0000ffff);
    wr(8'h10, 32'h0);
    chk("xn_resp", 48'h2, resp);
    rdr(8'h08);
    chk("xm_lo", 48'haaaa5555, rd);
    rdr(8'h0c);
    chk("xm_hi", 48'h1234, rd[15:0]);
    rdr(8'h10);
    chk("xn", 48'hffff, rd[15:0]);
    rdr(8'h20);
    chk("bad_resp", 48'h2, resp);
    chk("bad_data", 48'h0, rd);
  endtask : t_freq

  // Main sequence: each boot source, then host traffic on the last image.
  initial
  begin
    boot(2'h0, 10'h114, 1'b0);
    boot(2'h2, 10'h096, 1'b0);
    boot(2'h1, 10'h0c8, 1'b1);
    t_lock();
    t_cfg();
    t_freq();
    end_of_test();
  end
endmodule : test_system_system_analog_pll_config_status
